// ==== common/sl_pkg.sv ====
// Shared constants and types for the serial link control block
package sl_pkg;

    typedef enum logic [2:0] {
        LVL_LOW  = 3'b001,
        LVL_MID  = 3'b010,
        LVL_HIGH = 3'b100
    } sl_lvl_e;

    typedef enum logic [1:0] {
        RC_TRACK = 2'b01,
        RC_FORCE = 2'b10
    } sl_rc_e;

    // Three-level pad code: [1] above high trip, [0] below low trip
    localparam logic [1:0] TRI_HI_CODE = 2'h2;
    localparam logic [1:0] TRI_LO_CODE = 2'h1;

    localparam logic [4:0] MULT_LO = 5'h0a;
    localparam logic [4:0] MULT_HI = 5'h14;

    localparam int         RANGE_PERIOD_REFS = 16000;
    localparam int         RC_CNT_W          = 14;

    localparam logic [2:0] TD_IDLE_CHARS = 3'h7;
    localparam logic [1:0] TD_GOOD_LAST  = 2'h2;

    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STAT_ADDR = 4'h1;
    localparam logic [7:0] CTRL_RST  = 8'h01;
    localparam int         CTRL_RC_EN_BIT = 0;

    typedef struct packed {
        logic [1:0] enable_select_bits;
        logic       output_latch_enable;
        logic       receive_latch_enable;
        logic       device_reset_n;
        logic       transmit_rate_select;
        logic [1:0] transmit_input_clock_select;
        logic [1:0] speed_range_select;
        logic [1:0] amplitude_threshold_select;
        logic       line_input_select;
        logic       loopback_enable;
        logic [2:0] first_line_amp;
        logic [2:0] second_line_amp;
        logic       vco_in_range;
    } sl_pins_s;

    function automatic sl_lvl_e sl_tri_decode(input logic [1:0] code);
        case (code)
            TRI_HI_CODE: sl_tri_decode = LVL_HIGH;
            TRI_LO_CODE: sl_tri_decode = LVL_LOW;
            default:     sl_tri_decode = LVL_MID;
        endcase
    endfunction

endpackage

// ==== rtl/sl_trans_mon.sv ====
// Transition density monitor for received characters
`timescale 1ns/10ps
`default_nettype none
module sl_trans_mon (
    input  wire logic ref_clk_i,    // Reference clock
    input  wire logic sys_rst_i,    // Sync reset, active high
    input  wire logic ce_i,         // Clock enable
    input  wire logic char_stb_i,   // One received character
    input  wire logic char_trans_i, // Character held a transition
    output logic      fault_o       // Missing transitions
);
    import sl_pkg::*;

    logic [2:0] idle_cnt_reg;
    logic [1:0] good_cnt_reg;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            idle_cnt_reg <= '0;
            good_cnt_reg <= '0;
            fault_o      <= 1'b1;
        end else if (ce_i && char_stb_i) begin
            if (char_trans_i) begin
                idle_cnt_reg <= '0;
                if (fault_o && good_cnt_reg == TD_GOOD_LAST) begin
                    fault_o      <= 1'b0;
                    good_cnt_reg <= '0;
                end else if (fault_o) begin
                    good_cnt_reg <= good_cnt_reg + 2'h1;
                end
            end else begin
                good_cnt_reg <= '0;
                if (idle_cnt_reg != TD_IDLE_CHARS) begin
                    idle_cnt_reg <= idle_cnt_reg + 3'h1;
                end
                // Seventh empty character exceeds 60 bit times
                if (idle_cnt_reg + 3'h1 == TD_IDLE_CHARS) begin
                    fault_o <= 1'b1;
                end
            end
        end
    end

    AST_IDLE_FAULT: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ce_i && char_stb_i && !char_trans_i && idle_cnt_reg == 3'h6
        |=> fault_o)
        else $error("fault not raised after seven idle characters");

    AST_FAULT_CLEAR: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        $fell(fault_o) |-> $past(good_cnt_reg) == 2'h2
            && $past(char_trans_i) && $past(char_stb_i))
        else $error("fault cleared before three good characters");

    COV_FAULT_CLEARS: cover property (@(posedge ref_clk_i)
        disable iff (sys_rst_i) $fell(fault_o));

endmodule
`default_nettype wire

// ==== rtl/sl_link_ctrl.sv ====
// Serial link enables, rate selection and link fault detection
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sl_link_ctrl #(
    parameter int RANGE_PERIOD = sl_pkg::RANGE_PERIOD_REFS // Refs per check
) (
    input  wire logic        ref_clk_i,          // 25 MHz clock
    input  wire logic        sys_rst_i,          // Sync reset, high
    input  wire logic        ce_i,               // Clock enable
    input  wire logic [1:0]  enable_select_bits_i, // Enable select pins
    input  wire logic        output_latch_enable_i,  // Output latch open
    input  wire logic        receive_latch_enable_i, // Rx latch open
    input  wire logic        device_reset_n_i,   // Device reset pin
    input  wire logic        transmit_rate_select_i, // 1: x20
    input  wire logic [1:0]  transmit_input_clock_select_i, // 3-level
    input  wire logic [1:0]  speed_range_select_i, // 3-level
    input  wire logic [1:0]  amplitude_threshold_select_i, // 3-level
    input  wire logic        line_input_select_i, // 1: second input
    input  wire logic        loopback_enable_i,   // Local loopback
    input  wire logic [2:0]  first_line_amp_i,    // Amp trips input 1
    input  wire logic [2:0]  second_line_amp_i,   // Amp trips input 2
    input  wire logic        vco_in_range_i,      // VCO near reference
    input  wire logic        rx_char_stb_i,       // Received character
    input  wire logic        rx_char_trans_i,     // It had a transition
    input  wire logic        tx_serial_bit_i,     // Transmit bit
    input  wire logic [3:0]  reg_addr_i,          // Register address
    input  wire logic [7:0]  reg_wdata_i,         // Write data
    input  wire logic        reg_wr_i,            // Write strobe
    input  wire logic        reg_rd_i,            // Read strobe
    output logic [7:0]       reg_rdata_o,         // Read data
    output logic             first_serial_output_en_o,  // Driver 1 on
    output logic             second_serial_output_en_o, // Driver 2 on
    output logic             first_serial_output_o,     // Driver 1 bit
    output logic             second_serial_output_o,    // Driver 2 bit
    output logic             tx_lowpower_o,       // Tx logic asleep
    output logic [4:0]       tx_mult_factor_o,    // 10 or 20
    output logic             tx_char_clk_x2_o,    // Char clock 2x ref
    output sl_pkg::sl_lvl_e  speed_range_o,       // Decoded range
    output logic             speed_reserved_o,    // Reserved setting
    output logic             clock_select_invalid_o, // Bad combination
    output logic             rx_line_sel_o,       // Routed receiver
    output logic             loopback_route_o,    // Internal loop on
    output sl_pkg::sl_lvl_e  amp_threshold_o,     // Decoded threshold
    output logic             rx_enable_o,         // Rx channel on
    output logic             range_force_o,       // VCO forced
    output logic             link_fault_indicator_n_o // Low: fault
);
    import sl_pkg::*;

    sl_pins_s            pin_raw;
    sl_pins_s            pin_meta_reg;
    sl_pins_s            pin_reg;
    logic [1:0]          drv_en_reg;
    logic [1:0]          drv_en_next;
    logic [7:0]          ctrl_reg;
    sl_rc_e              rc_state_reg;
    logic [RC_CNT_W-1:0] rc_cnt_reg;
    logic                period_end;
    logic                trans_fault;
    logic                amp_ok;
    logic [2:0]          amp_sel;
    sl_lvl_e             spd_lvl;
    sl_lvl_e             amp_lvl;
    sl_lvl_e             ckl_lvl;

    assign pin_raw = '{
        enable_select_bits:          enable_select_bits_i,
        output_latch_enable:         output_latch_enable_i,
        receive_latch_enable:        receive_latch_enable_i,
        device_reset_n:              device_reset_n_i,
        transmit_rate_select:        transmit_rate_select_i,
        transmit_input_clock_select: transmit_input_clock_select_i,
        speed_range_select:          speed_range_select_i,
        amplitude_threshold_select:  amplitude_threshold_select_i,
        line_input_select:           line_input_select_i,
        loopback_enable:             loopback_enable_i,
        first_line_amp:              first_line_amp_i,
        second_line_amp:             second_line_amp_i,
        vco_in_range:                vco_in_range_i
    };

    // Pins are asynchronous; only pin_reg is read by logic
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pin_meta_reg <= '0;
            pin_reg      <= '0;
        end else if (ce_i) begin
            pin_meta_reg <= pin_raw;
            pin_reg      <= pin_meta_reg;
        end
    end

    assign spd_lvl = sl_tri_decode(pin_reg.speed_range_select);
    assign amp_lvl = sl_tri_decode(pin_reg.amplitude_threshold_select);
    assign ckl_lvl = sl_tri_decode(pin_reg.transmit_input_clock_select);

    // Output enable latch: device reset clears it, else transparent while open, holds once closed
    always_comb begin
        drv_en_next = drv_en_reg;
        if (!pin_reg.device_reset_n) begin
            drv_en_next = '0;
        end else if (pin_reg.output_latch_enable) begin
            drv_en_next = pin_reg.enable_select_bits;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            drv_en_reg <= '0;
        end else if (ce_i) begin
            drv_en_reg <= drv_en_next;
        end
    end

    // Receive enable latch follows bit zero while its latch is open
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rx_enable_o <= 1'b0;
        end else if (ce_i && pin_reg.receive_latch_enable) begin
            rx_enable_o <= pin_reg.enable_select_bits[0];
        end
    end

    // Driver outputs; disabled drivers idle low to save power
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            first_serial_output_en_o  <= 1'b0;
            second_serial_output_en_o <= 1'b0;
            first_serial_output_o     <= 1'b0;
            second_serial_output_o    <= 1'b0;
            tx_lowpower_o             <= 1'b1;
            loopback_route_o          <= 1'b0;
        end else if (ce_i) begin
            first_serial_output_en_o  <= drv_en_reg[0];
            second_serial_output_en_o <= drv_en_reg[1];
            first_serial_output_o     <= drv_en_reg[0]
                && (pin_reg.loopback_enable || tx_serial_bit_i);
            second_serial_output_o    <= drv_en_reg[1]
                && (pin_reg.loopback_enable || tx_serial_bit_i);
            tx_lowpower_o             <= ~|drv_en_reg;
            loopback_route_o          <= pin_reg.loopback_enable;
        end
    end

    // Clock multiplier and range selection
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tx_mult_factor_o       <= MULT_LO;
            tx_char_clk_x2_o       <= 1'b0;
            speed_range_o          <= LVL_MID;
            speed_reserved_o       <= 1'b0;
            clock_select_invalid_o <= 1'b0;
            amp_threshold_o        <= LVL_MID;
            rx_line_sel_o          <= 1'b0;
        end else if (ce_i) begin
            tx_mult_factor_o <= pin_reg.transmit_rate_select
                ? MULT_HI : MULT_LO;
            // Half-character-rate reference needs doubled char clock
            tx_char_clk_x2_o <= pin_reg.transmit_rate_select;
            speed_range_o    <= spd_lvl;
            speed_reserved_o <= (spd_lvl == LVL_LOW)
                && pin_reg.transmit_rate_select;
            // Flagged only; the host owns this combination
            clock_select_invalid_o <= (ckl_lvl != LVL_LOW)
                && pin_reg.transmit_rate_select;
            amp_threshold_o  <= amp_lvl;
            rx_line_sel_o    <= pin_reg.line_input_select;
        end
    end

    // Amplitude of the routed receiver only; ignored in loopback
    assign amp_sel = pin_reg.line_input_select
        ? pin_reg.second_line_amp : pin_reg.first_line_amp;
    assign amp_ok = pin_reg.loopback_enable
        || (|(amp_sel & amp_lvl));

    // Range control sampling period
    assign period_end = rc_cnt_reg == RC_CNT_W'(RANGE_PERIOD - 1);

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rc_cnt_reg <= '0;
        end else if (ce_i) begin
            rc_cnt_reg <= period_end ? '0
                : rc_cnt_reg + RC_CNT_W'(1);
        end
    end

    // Force lasts one period, then releases for a relock attempt
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rc_state_reg <= RC_TRACK;
        end else if (ce_i && period_end) begin
            case (rc_state_reg)
                RC_TRACK: begin
                    if (!pin_reg.vco_in_range && rx_enable_o
                        && ctrl_reg[CTRL_RC_EN_BIT]) begin
                        rc_state_reg <= RC_FORCE;
                    end
                end
                RC_FORCE: rc_state_reg <= RC_TRACK;
                default:  rc_state_reg <= RC_TRACK;
            endcase
        end
    end

    sl_trans_mon u_trans_mon (
        .ref_clk_i    (ref_clk_i),
        .sys_rst_i    (sys_rst_i),
        .ce_i         (ce_i),
        .char_stb_i   (rx_char_stb_i),
        .char_trans_i (rx_char_trans_i),
        .fault_o      (trans_fault)
    );

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            range_force_o            <= 1'b0;
            link_fault_indicator_n_o <= 1'b0;
        end else if (ce_i) begin
            range_force_o <= rc_state_reg == RC_FORCE;
            link_fault_indicator_n_o <= amp_ok && !trans_fault
                && rx_enable_o && pin_reg.vco_in_range
                && rc_state_reg == RC_TRACK;
        end
    end

    // Register port
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= CTRL_RST;
        end else if (ce_i && reg_wr_i && reg_addr_i == CTRL_ADDR) begin
            ctrl_reg <= reg_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
        end else if (ce_i) begin
            reg_rdata_o <= '0;
            if (reg_rd_i && reg_addr_i == CTRL_ADDR) begin
                reg_rdata_o <= ctrl_reg;
            end else if (reg_rd_i && reg_addr_i == STAT_ADDR) begin
                reg_rdata_o <= {link_fault_indicator_n_o, range_force_o,
                    trans_fault, rx_enable_o, loopback_route_o,
                    tx_lowpower_o, drv_en_reg};
            end
        end
    end

    AST_DRV_ON: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ce_i && pin_reg.device_reset_n && pin_reg.output_latch_enable
        && pin_reg.enable_select_bits[1] |=> drv_en_reg[1])
        else $error("driver two not enabled");

    AST_DRV_OFF: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ce_i && pin_reg.output_latch_enable
        && !pin_reg.enable_select_bits[0] |=> !drv_en_reg[0])
        else $error("driver one not disabled");

    AST_LOWPWR: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ce_i && tx_lowpower_o |-> $past(drv_en_reg) == 2'h0)
        else $error("low power with a driver enabled");

    AST_HOLD: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        pin_reg.device_reset_n && !pin_reg.output_latch_enable
        |=> $stable(drv_en_reg))
        else $error("closed latch changed");

    AST_DEV_RST: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ce_i && !pin_reg.device_reset_n |=> drv_en_reg == 2'h0)
        else $error("device reset did not clear latch");

    AST_MULT: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ce_i |=> tx_mult_factor_o
            == ($past(pin_reg.transmit_rate_select) ? MULT_HI : MULT_LO))
        else $error("wrong multiply factor");

    AST_LOOP_ONE: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ce_i && pin_reg.loopback_enable && drv_en_reg[0]
        |=> first_serial_output_o)
        else $error("loopback output not static one");

    AST_RX_OFF: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ce_i && !rx_enable_o |=> !link_fault_indicator_n_o)
        else $error("fault not shown with rx disabled");

    AST_FORCE_LFI: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ce_i && rc_state_reg == RC_FORCE |=> !link_fault_indicator_n_o)
        else $error("fault not shown while forced");

    AST_RC_PERIOD: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        rc_state_reg != $past(rc_state_reg) |-> $past(period_end))
        else $error("range state moved mid period");

    COV_LINK_VALID: cover property (@(posedge ref_clk_i)
        disable iff (sys_rst_i) $rose(link_fault_indicator_n_o));
    COV_FORCE: cover property (@(posedge ref_clk_i)
        disable iff (sys_rst_i) rc_state_reg == RC_FORCE);
    COV_LOOPBACK: cover property (@(posedge ref_clk_i)
        disable iff (sys_rst_i) loopback_route_o && drv_en_reg[0]);

endmodule
`default_nettype wire

// ==== dv/sl_line_model.sv ====
// Far-end line model: characters, amplitude trips and frequency
`timescale 1ns/10ps
`default_nettype none
module sl_line_model (
    input  wire logic       ref_clk_i,   // Reference clock
    input  wire logic [2:0] amp_i,       // Trips on the driven input
    input  wire logic       on_second_i, // Drive second input
    input  wire logic       dead_i,      // Send no transitions
    input  wire logic       freq_bad_i,  // Run off frequency
    output logic [2:0]      amp1_o,      // First input trips
    output logic [2:0]      amp2_o,      // Second input trips
    output logic            stb_o,       // Character strobe
    output logic            trans_o,     // Character had a transition
    output logic            vco_ok_o     // VCO near reference
);
    logic [1:0] div_reg = 2'h0;
    always_ff @(posedge ref_clk_i) begin
        div_reg <= div_reg + 2'h1;
        stb_o   <= (div_reg == 2'h3);
        // Flips off-strobe so a stale flag never looks meaningful
        trans_o <= (div_reg == 2'h3) ? !dead_i : !trans_o;
    end
    // An undriven input carries no signal, so nothing trips
    assign amp1_o   = on_second_i ? 3'h0 : amp_i;
    assign amp2_o   = on_second_i ? amp_i : 3'h0;
    assign vco_ok_o = !freq_bad_i;
endmodule
`default_nettype wire

// ==== dv/test_sl_link_ctrl.sv ====
// Self-checking bench for the serial link control block
`timescale 1ns/10ps
`default_nettype none
module test_sl_link_ctrl;
    import sl_pkg::*;
    localparam int RP = 20;
    logic       ref_clk_i = 1'b0, rst = 1'b1, out_le = 1'b0, rx_le = 1'b0;
    logic       dev_n = 1'b1, rate = 1'b0, in_sel = 1'b0, loop_en = 1'b0;
    logic       ce = 1'b1;
    logic       dead = 1'b0, fbad = 1'b0, sec = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [1:0] bits = 2'h0, csel = 2'h1, spd = 2'h0, thr = 2'h1;
    logic [2:0] amp = 3'h7, amp1, amp2;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h0, rdata;
    logic       stb, trans, vco_ok, en1, en2, first_serial_output, second_serial_output, lowp, x2;
    logic       resv, inval, lsel, lroute, rxen, frc, fault_n;
    logic [4:0] mult;
    sl_lvl_e    spd_lvl, thr_lvl;
    int         err_total = 0, check_count = 0, cyc = 0;

    sl_line_model u_line (.ref_clk_i(ref_clk_i), .amp_i(amp),
        .on_second_i(sec), .dead_i(dead), .freq_bad_i(fbad), .amp1_o(amp1),
        .amp2_o(amp2), .stb_o(stb), .trans_o(trans), .vco_ok_o(vco_ok));

    sl_link_ctrl #(.RANGE_PERIOD(RP)) u_dut (.ref_clk_i(ref_clk_i),
        .sys_rst_i(rst), .ce_i(ce), .enable_select_bits_i(bits),
        .output_latch_enable_i(out_le), .receive_latch_enable_i(rx_le),
        .device_reset_n_i(dev_n), .transmit_rate_select_i(rate),
        .transmit_input_clock_select_i(csel), .speed_range_select_i(spd),
        .amplitude_threshold_select_i(thr), .line_input_select_i(in_sel),
        .loopback_enable_i(loop_en), .first_line_amp_i(amp1),
        .second_line_amp_i(amp2), .vco_in_range_i(vco_ok),
        .rx_char_stb_i(stb), .rx_char_trans_i(trans),
        .tx_serial_bit_i(1'b0), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .first_serial_output_en_o(en1), .second_serial_output_en_o(en2),
        .first_serial_output_o(first_serial_output), .second_serial_output_o(second_serial_output),
        .tx_lowpower_o(lowp), .tx_mult_factor_o(mult),
        .tx_char_clk_x2_o(x2), .speed_range_o(spd_lvl),
        .speed_reserved_o(resv), .clock_select_invalid_o(inval),
        .rx_line_sel_o(lsel), .loopback_route_o(lroute),
        .amp_threshold_o(thr_lvl), .rx_enable_o(rxen),
        .range_force_o(frc), .link_fault_indicator_n_o(fault_n));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk_i);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk_i);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic t_regs;
        logic [7:0] d;
        reg_rd(CTRL_ADDR, d);
        chk(d, CTRL_RST);
        // Unmapped place: write ignored, read gives zero
        reg_wr(4'h9, 8'hff);
        reg_rd(4'h9, d);
        chk(d, 8'h00);
        reg_wr(CTRL_ADDR, 8'h00);
        reg_rd(CTRL_ADDR, d);
        chk(d, 8'h00);
        reg_wr(CTRL_ADDR, 8'h01);
        $display("done regs");
    endtask

    task automatic t_drivers;
        logic [7:0] d;
        wt(1);
        chk(lowp, 1'b1);
        @(posedge ref_clk_i);
        out_le <= 1'b1;
        bits   <= 2'b10;
        wt(6);
        chk({en2, en1}, 2'b10);
        chk(lowp, 1'b0);
        @(posedge ref_clk_i);
        bits <= 2'b01;
        wt(6);
        chk({en2, en1, second_serial_output}, 3'b010);
        @(posedge ref_clk_i);
        out_le <= 1'b0;
        wt(6);
        @(posedge ref_clk_i);
        bits <= 2'b00;
        wt(6);
        chk({en2, en1}, 2'b01);
        reg_rd(STAT_ADDR, d);
        chk(d[1:0], 2'b01);
        @(posedge ref_clk_i);
        dev_n <= 1'b0;
        wt(6);
        chk({en2, en1, lowp}, 3'b001);
        @(posedge ref_clk_i);
        dev_n  <= 1'b1;
        out_le <= 1'b1;
        bits   <= 2'b11;
        // Only enables judged here; line data may still be settling
        wt(6);
        chk({en2, en1}, 2'b11);
        $display("done drivers");
    endtask

    task automatic t_rates;
        logic [1:0] code [3] = '{2'b01, 2'b00, 2'b10};
        sl_lvl_e    lv [3]   = '{LVL_LOW, LVL_MID, LVL_HIGH};
        for (int i = 0; i < 3; i++) begin
            for (int r = 0; r < 2; r++) begin
                @(posedge ref_clk_i);
                {spd, thr, csel} <= {code[i], code[i], code[i]};
                rate <= r[0];
                wt(6);
                chk(spd_lvl, lv[i]);
                chk(thr_lvl, lv[i]);
                chk(mult, r[0] ? MULT_HI : MULT_LO);
                chk(x2, r[0]);
                chk(resv, i == 0 && r == 1);
                chk(inval, i != 0 && r == 1);
            end
        end
        $display("done rates");
    endtask

    task automatic t_link;
        @(posedge ref_clk_i);
        {rx_le, rate, csel, thr, amp} <= {2'b10, 2'b01, 2'b01, 3'h3};
        wt(30);
        chk({rxen, fault_n}, 2'b11);
        @(posedge ref_clk_i);
        thr <= 2'b10;
        wt(6);
        chk(fault_n, 1'b0);
        @(posedge ref_clk_i);
        thr <= 2'b00;
        wt(6);
        chk(fault_n, 1'b1);
        @(posedge ref_clk_i);
        sec <= 1'b1;
        wt(6);
        chk(fault_n, 1'b0);
        @(posedge ref_clk_i);
        in_sel <= 1'b1;
        wt(6);
        chk({lsel, fault_n}, 2'b11);
        @(posedge ref_clk_i);
        amp <= 3'h0;
        wt(6);
        chk(fault_n, 1'b0);
        @(posedge ref_clk_i);
        loop_en <= 1'b1;
        wt(6);
        chk({fault_n, lroute, first_serial_output, second_serial_output}, 4'hf);
        @(posedge ref_clk_i);
        loop_en <= 1'b0;
        amp     <= 3'h7;
        dead    <= 1'b1;
        wt(22);
        chk(fault_n, 1'b1);
        wt(14);
        chk(fault_n, 1'b0);
        @(posedge ref_clk_i);
        dead <= 1'b0;
        wt(5);
        chk(fault_n, 1'b0);
        wt(15);
        chk(fault_n, 1'b1);
        @(posedge ref_clk_i);
        bits <= 2'b10;
        wt(6);
        chk({rxen, fault_n}, 2'b00);
        @(posedge ref_clk_i);
        bits <= 2'b11;
        wt(30);
        $display("done link");
    endtask

    task automatic t_range;
        @(posedge ref_clk_i);
        fbad <= 1'b1;
        for (int i = 0; i < 3 * RP + 10 && frc !== 1'b1; i++)
            wt(1);
        chk(frc, 1'b1);
        @(posedge ref_clk_i);
        fbad <= 1'b0;
        wt(6);
        chk({frc, fault_n}, 2'b10);
        wt(RP + 10);
        chk({frc, fault_n}, 2'b01);
        $display("done range");
    endtask

    // Clock enable low must freeze the pin path and the driver latch
    task automatic t_freeze;
        @(posedge ref_clk_i);
        ce   <= 1'b0;
        bits <= 2'b01;
        wt(8);
        chk({en2, en1}, 2'b11);
        @(posedge ref_clk_i);
        ce <= 1'b1;
        wt(6);
        chk({en2, en1}, 2'b01);
        $display("done freeze");
    endtask

    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst <= 1'b0;
        wt(3);
        chk({en2, en1, fault_n}, 3'b000);
        chk(mult, MULT_LO);
        t_regs();
        t_drivers();
        t_rates();
        t_link();
        t_range();
        t_freeze();
        end_sim();
    end
endmodule
`default_nettype wire
